// ### logic/dts_pkg.sv
// constants, register map and state types of the temperature sensor core
`default_nettype none
package dts_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned CONV_TIME_MS = 125;
  localparam int unsigned CONV_CYC = CONV_TIME_MS * CLK_KHZ;
  localparam int unsigned GAP_TIME_MS = 250;
  localparam int unsigned GAP_CYC = GAP_TIME_MS * CLK_KHZ;
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  // ---------------------------------------------------------------
  // command byte values (register pointers)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] REG_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h03;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_LOCAL_HIGH = 8'h05;
  localparam logic [7:0] REG_LOCAL_LOW = 8'h06;
  localparam logic [7:0] REG_REMOTE_HIGH = 8'h07;
  localparam logic [7:0] REG_REMOTE_LOW = 8'h08;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;
  localparam logic [7:0] REG_REMOTE_FRAC = 8'h10;
  localparam logic [7:0] REG_LOCAL_FRAC = 8'h11;
  localparam logic [7:0] REG_REMOTE_OVER = 8'h19;
  localparam logic [7:0] REG_LOCAL_OVER = 8'h20;
  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h07;
  localparam logic [7:0] RST_LOCAL_HIGH = 8'h55;
  localparam logic [7:0] RST_REMOTE_HIGH = 8'h5F;
  localparam logic [7:0] RST_LOW = 8'h00;
  localparam logic [7:0] RST_LOCAL_OVER = 8'h55;
  localparam logic [7:0] RST_REMOTE_OVER = 8'h7D;
  localparam logic [7:0] FAULT_TEMP = 8'hFF;
  localparam int unsigned CFG_MASK_BIT = 7;
  localparam int unsigned CFG_RUN_N_BIT = 6;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // flag vector order: local high, local low, remote high, remote low, open
  localparam int unsigned FLAG_OPEN = 0;
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    SM_IDLE = 7'h01,
    SM_ADDR = 7'h02,
    SM_AACK = 7'h04,
    SM_RX = 7'h08,
    SM_RACK = 7'h10,
    SM_TX = 7'h20,
    SM_MACK = 7'h40
  } dts_sm_type;
  typedef enum logic [1:0] {
    CV_WAIT = 2'h1,
    CV_CONV = 2'h2
  } dts_cv_type;
endpackage
`default_nettype wire

// ### logic/dts_core.sv
// two-channel temperature sensor: conversion, limits, smbus register slave
`default_nettype none
module dts_core
  import dts_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A, // arbitrary value
  parameter int unsigned CONV_CYCLES = CONV_CYC,
  parameter int unsigned GAP_CYCLES = GAP_CYC,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // smbus pins
  input wire logic SCLK_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // alarm pins, open drain
  output logic ALERT_OUT,
  output logic ALERT_OE,
  output logic OVERHEAT_SHUTDOWN_OUT,
  output logic OVERHEAT_SHUTDOWN_OE,
  // analog front end results, eighths of a degree, signed
  input wire logic [11:0] LOCAL_MEAS,
  input wire logic [11:0] REMOTE_MEAS,
  input wire logic REMOTE_OPEN,
  input wire logic REMOTE_SHORT
);
  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    dts_sm_type sm;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rd;
    logic ara;
    logic got_cmd;
    logic [7:0] cmd_ptr;
    logic sda_oe;
    logic [31:0] to_cnt;
    dts_cv_type cv;
    logic oneshot;
    logic [31:0] cv_cnt;
    logic [7:0] lt;
    logic [7:0] rt;
    logic [7:0] lfrac;
    logic [7:0] rfrac;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi;
    logic [7:0] rlo;
    logic [7:0] lov;
    logic [7:0] rov;
    logic [4:0] sts;
    logic alert;
    logic overheat_shutdown_out;
  } dts_st_type;

  // sync flops start high so that release of reset is no start condition
  localparam dts_st_type ST_RESET = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
    sm: SM_IDLE, cv: CV_WAIT,
    cfg: RST_CONFIG, rate: RST_RATE,
    lhi: RST_LOCAL_HIGH, llo: RST_LOW,
    rhi: RST_REMOTE_HIGH, rlo: RST_LOW,
    lov: RST_LOCAL_OVER, rov: RST_REMOTE_OVER,
    default: '0
  };

  dts_st_type r_reg;
  dts_st_type r_next;
  logic busy;
  logic osh;
  logic status_rd;
  logic ara_done;
  logic conv_done;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // limit violations of a pair of readings against the stored limits
  function automatic logic [4:0] violations(input dts_st_type s,
                                            input logic [7:0] l,
                                            input logic [7:0] m,
                                            input logic open);
    violations = {l >= s.lhi, l < s.llo, m >= s.rhi, m < s.rlo, open};
  endfunction

  // register read decode, used for first and following read bytes
  function automatic logic [7:0] read_reg(input dts_st_type s,
                                          input logic bsy);
    case (s.cmd_ptr)
      REG_LOCAL_TEMP: read_reg = s.lt;
      REG_REMOTE_TEMP: read_reg = s.rt;
      REG_STATUS: read_reg = {bsy, s.sts, 2'h0};
      REG_CONFIG: read_reg = s.cfg;
      REG_RATE: read_reg = s.rate;
      REG_LOCAL_HIGH: read_reg = s.lhi;
      REG_LOCAL_LOW: read_reg = s.llo;
      REG_REMOTE_HIGH: read_reg = s.rhi;
      REG_REMOTE_LOW: read_reg = s.rlo;
      REG_REMOTE_FRAC: read_reg = s.rfrac;
      REG_LOCAL_FRAC: read_reg = s.lfrac;
      REG_REMOTE_OVER: read_reg = s.rov;
      REG_LOCAL_OVER: read_reg = s.lov;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [7:0] txb;
    logic [7:0] lt_new;
    logic [7:0] rt_new;
    logic [4:0] now_v;
    logic [4:0] new_v;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    txb = 8'h00;
    lt_new = 8'h00;
    rt_new = 8'h00;
    now_v = 5'h00;
    new_v = 5'h00;
    r_next = r_reg;
    busy = (r_reg.cv == CV_CONV);
    osh = 1'b0;
    status_rd = 1'b0;
    ara_done = 1'b0;
    conv_done = 1'b0;
    // three flops per pin; the second and third feed the edge logic
    r_next.scl_s1 = SCLK_IN;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d = r_reg.scl_s2;
    r_next.sda_s1 = SDA_IN;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d = r_reg.sda_s2;
    scl_rise = r_reg.scl_s2 & ~r_reg.scl_d;
    scl_fall = ~r_reg.scl_s2 & r_reg.scl_d;
    start = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_s2 & r_reg.sda_d;
    stop = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_s2 & ~r_reg.sda_d;
    txb = r_reg.ara ? {SLAVE_ADDR, 1'b0} : read_reg(r_reg, busy);

    case (r_reg.sm)
      SM_IDLE: begin
      end
      SM_ADDR: begin
        if (scl_rise) begin
          r_next.shreg = {r_reg.shreg[6:0], r_reg.sda_s2};
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
        end else if (scl_fall && r_reg.bitcnt == BYTE_BITS) begin
          r_next.rd = r_reg.shreg[0];
          r_next.ara = 1'b0;
          r_next.got_cmd = 1'b0;
          r_next.sm = SM_IDLE;
          if (r_reg.shreg[7:1] == SLAVE_ADDR) begin
            r_next.sm = SM_AACK;
            r_next.sda_oe = 1'b1;
          end else if (r_reg.shreg == {ARA_ADDR, 1'b1} && r_reg.alert) begin
            // answer the alert response only while our alert is pending
            r_next.ara = 1'b1;
            r_next.sm = SM_AACK;
            r_next.sda_oe = 1'b1;
          end
        end
      end
      SM_AACK: begin
        if (scl_fall) begin
          r_next.bitcnt = 4'h0;
          r_next.sda_oe = 1'b0;
          r_next.sm = SM_RX;
          if (r_reg.rd) begin
            // receive byte uses the stored pointer
            r_next.shreg = txb;
            r_next.sda_oe = ~txb[7];
            r_next.bitcnt = 4'h1;
            r_next.sm = SM_TX;
          end
        end
      end
      SM_RX: begin
        if (scl_rise) begin
          r_next.shreg = {r_reg.shreg[6:0], r_reg.sda_s2};
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
        end else if (scl_fall && r_reg.bitcnt == BYTE_BITS) begin
          r_next.got_cmd = 1'b1;
          r_next.sda_oe = 1'b1;
          r_next.sm = SM_RACK;
          if (!r_reg.got_cmd && r_reg.shreg == CMD_ONE_SHOT) begin
            osh = 1'b1;
          end else if (!r_reg.got_cmd) begin
            r_next.cmd_ptr = r_reg.shreg;
          end else begin
            // writes land on the selected register; read-only ones ignore
            case (r_reg.cmd_ptr)
              REG_CONFIG: r_next.cfg = r_reg.shreg;
              REG_RATE: r_next.rate = r_reg.shreg;
              REG_LOCAL_HIGH: r_next.lhi = r_reg.shreg;
              REG_LOCAL_LOW: r_next.llo = r_reg.shreg;
              REG_REMOTE_HIGH: r_next.rhi = r_reg.shreg;
              REG_REMOTE_LOW: r_next.rlo = r_reg.shreg;
              REG_REMOTE_OVER: r_next.rov = r_reg.shreg;
              REG_LOCAL_OVER: r_next.lov = r_reg.shreg;
              default: r_next.cfg = r_reg.cfg;
            endcase
          end
        end
      end
      SM_RACK: begin
        if (scl_fall) begin
          r_next.sda_oe = 1'b0;
          r_next.bitcnt = 4'h0;
          r_next.sm = SM_RX;
        end
      end
      SM_TX: begin
        if (scl_fall && r_reg.bitcnt == BYTE_BITS) begin
          r_next.sda_oe = 1'b0;
          r_next.sm = SM_MACK;
          ara_done = r_reg.ara;
          status_rd = ~r_reg.ara && r_reg.cmd_ptr == REG_STATUS;
        end else if (scl_fall) begin
          r_next.shreg = {r_reg.shreg[6:0], 1'b0};
          r_next.sda_oe = ~r_reg.shreg[6];
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
        end
      end
      SM_MACK: begin
        // master ack asks for one more byte of the same register
        if (scl_rise) begin
          r_next.sm = r_reg.sda_s2 ? SM_IDLE : SM_AACK;
        end
      end
      default: r_next.sm = SM_IDLE;
    endcase

    // framing: start or stop restarts the byte machine
    if (start) begin
      r_next.sm = SM_ADDR;
      r_next.bitcnt = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop) begin
      r_next.sm = SM_IDLE;
      r_next.sda_oe = 1'b0;
    end

    // clock-low watchdog frees a hung bus
    r_next.to_cnt = 32'h0;
    if (!r_reg.scl_s2 && r_reg.sm != SM_IDLE) begin
      r_next.to_cnt = r_reg.to_cnt + 32'h1;
    end
    if (r_reg.to_cnt >= TIMEOUT_CYCLES) begin
      r_next.sm = SM_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.to_cnt = 32'h0;
    end

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    case (r_reg.cv)
      CV_WAIT: begin
        // standby holds the rate timer at zero
        r_next.cv_cnt = 32'h0;
        if (!r_reg.cfg[CFG_RUN_N_BIT]) begin
          r_next.cv_cnt = r_reg.cv_cnt + 32'h1;
          if (r_reg.cv_cnt >= GAP_CYCLES - 1) begin
            r_next.cv = CV_CONV;
            r_next.cv_cnt = 32'h0;
            r_next.oneshot = 1'b0;
          end
        end
        // one-shot starts regardless of the run bit
        if (osh) begin
          r_next.cv = CV_CONV;
          r_next.cv_cnt = 32'h0;
          r_next.oneshot = 1'b1;
        end
      end
      CV_CONV: begin
        r_next.cv_cnt = r_reg.cv_cnt + 32'h1;
        if (r_reg.cfg[CFG_RUN_N_BIT] && !r_reg.oneshot) begin
          r_next.cv = CV_WAIT;
          r_next.cv_cnt = 32'h0;
        end else if (r_reg.cv_cnt >= CONV_CYCLES - 1) begin
          // end of the 125 ms busy period
          r_next.cv = CV_WAIT;
          r_next.cv_cnt = 32'h0;
          conv_done = 1'b1;
        end
      end
      default: r_next.cv = CV_WAIT;
    endcase

    lt_new = LOCAL_MEAS[11] ? 8'h00 : LOCAL_MEAS[10:3];
    rt_new = REMOTE_MEAS[11] ? 8'h00 : REMOTE_MEAS[10:3];
    if (REMOTE_OPEN || REMOTE_SHORT) begin
      rt_new = FAULT_TEMP;
    end
    // open condition is the live diode state, else the flag could never clear
    now_v = violations(r_reg, r_reg.lt, r_reg.rt, REMOTE_OPEN);
    new_v = violations(r_reg, lt_new, rt_new, REMOTE_OPEN);

    // read or ARA clears only conditions that are gone
    if (status_rd) begin
      r_next.sts = r_reg.sts & now_v;
    end
    if ((status_rd || ara_done) && now_v == 5'h00) begin
      r_next.alert = 1'b0;
    end

    if (conv_done) begin
      // both channels latched from one sequence
      // main and fraction written in the same cycle
      r_next.lt = lt_new;
      r_next.rt = rt_new;
      r_next.lfrac = LOCAL_MEAS[11] ? 8'h00 : {LOCAL_MEAS[2:0], 5'h00};
      r_next.rfrac = (REMOTE_MEAS[11] || rt_new == FAULT_TEMP) ?
                     8'h00 : {REMOTE_MEAS[2:0], 5'h00};
      // flags set after clears so a new event wins
      r_next.sts = r_next.sts | new_v;
      // alert on high or low limit or open diode, unless masked
      if (new_v != 5'h00 && !r_reg.cfg[CFG_MASK_BIT]) begin
        r_next.alert = 1'b1;
      end
    end

    r_next.overheat_shutdown_out = (r_reg.lt >= r_reg.lov) || (r_reg.rt >= r_reg.rov);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // limits and clean status at reset
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      r_reg <= ST_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // open-drain pins only ever pull low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = r_reg.sda_oe;
  assign ALERT_OUT = 1'b0;
  assign ALERT_OE = r_reg.alert;
  assign OVERHEAT_SHUTDOWN_OUT = 1'b0;
  assign OVERHEAT_SHUTDOWN_OE = r_reg.overheat_shutdown_out;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_os_req;
    osh && !busy;
  endsequence
  sequence s_standby_mid;
    busy && r_reg.cfg[CFG_RUN_N_BIT] && !r_reg.oneshot;
  endsequence

  property p_busy_hold;
    busy && (!r_reg.cfg[CFG_RUN_N_BIT] || r_reg.oneshot) &&
      r_reg.cv_cnt < CONV_CYCLES - 1 |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped before the conversion time");

  property p_results_stable;
    busy ##1 busy |-> $stable(r_reg.lt) && $stable(r_reg.rfrac);
  endproperty
  a_results_stable: assert property (p_results_stable)
    else $error("results changed while busy");

  property p_standby_idle;
    !busy && !osh && r_reg.cfg[CFG_RUN_N_BIT] |=> !busy;
  endproperty
  a_standby_idle: assert property (p_standby_idle)
    else $error("conversion started in standby without one-shot");

  property p_oneshot;
    s_os_req |=> busy && r_reg.oneshot && r_reg.cv_cnt == 32'h0;
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("one-shot did not start a conversion");

  property p_abort;
    s_standby_mid |=> !busy && $stable(r_reg.lt) && $stable(r_reg.rt);
  endproperty
  a_abort: assert property (p_abort)
    else $error("standby did not abort or results changed");

  property p_fault_load;
    conv_done && (REMOTE_OPEN || REMOTE_SHORT)
      |=> r_reg.rt == FAULT_TEMP &&
          (r_reg.sts[FLAG_OPEN] || !$past(REMOTE_OPEN));
  endproperty
  a_fault_load: assert property (p_fault_load)
    else $error("diode fault not reflected in remote reading");

  property p_overheat_shutdown_out;
    r_reg.rt >= r_reg.rov ##1 r_reg.rt >= r_reg.rov |-> OVERHEAT_SHUTDOWN_OE;
  endproperty
  a_overheat_shutdown_out: assert property (p_overheat_shutdown_out)
    else $error("overheat output missing at remote limit");

  property p_alert_hold;
    r_reg.alert && !status_rd && !ara_done |=> ALERT_OE;
  endproperty
  a_alert_hold: assert property (p_alert_hold)
    else $error("alert cleared without acknowledge");

  property p_timeout;
    r_reg.to_cnt >= TIMEOUT_CYCLES |=> r_reg.sm == SM_IDLE && !SDA_OE;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("interface not reset after clock-low timeout");

  property p_frac_zero;
    conv_done |=> r_reg.lfrac[4:0] == 5'h00 && r_reg.rfrac[4:0] == 5'h00;
  endproperty
  a_frac_zero: assert property (p_frac_zero)
    else $error("fraction low bits not zero");
endmodule
`default_nettype wire

// ### dv/dts_smbus_host.sv
// smbus host model that drives the sensor's serial pins
`default_nettype none
module dts_smbus_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
  // pacing clock
  input wire logic clk,
  // bus lines, scl stands high between frames
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acked = 1'b1;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // steps on the falling edge keep changes off the sampling edge
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // start, or repeated start when scl is low
  task automatic start();
    w(5);
    sda_low = 1'b0;
    w(5);
    scl = 1'b1;
    w(10);
    sda_low = 1'b1;
    w(10);
    scl = 1'b0;
  endtask
  task automatic stop();
    w(5);
    sda_low = 1'b1;
    w(5);
    scl = 1'b1;
    w(10);
    sda_low = 1'b0;
    w(10);
  endtask
  task automatic put_bit(input logic b);
    w(5);
    sda_low = ~b;
    w(5);
    scl = 1'b1;
    w(10);
    scl = 1'b0;
  endtask
  // line released first, so a silent device reads as pull-up high
  task automatic get_bit(output logic b);
    w(5);
    sda_low = 1'b0;
    w(5);
    scl = 1'b1;
    w(5);
    b = sda;
    w(5);
    scl = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    acked = acked & ~a;
  endtask
  // last byte of a read is not acknowledged
  task automatic get_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    acked = 1'b1;
    start();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(c);
    put_byte(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    acked = 1'b1;
    start();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(c);
    start();
    put_byte({DEV_ADDR, 1'b1});
    get_byte(d);
    stop();
  endtask
  task automatic snd(input logic [7:0] c);
    acked = 1'b1;
    start();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(c);
    stop();
  endtask
  task automatic rcv(input logic [6:0] a, output logic [7:0] d);
    acked = 1'b1;
    d = 8'h00;
    start();
    put_byte({a, 1'b1});
    if (acked) begin
      get_byte(d);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// ### dv/tb_dual_temp_sensor_conversion_smbus.sv
// testbench: sensor core against an integer reference model
`default_nettype none
module tb_dual_temp_sensor_conversion_smbus;
  import dts_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADDR = 7'h2A; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] lm = 12'h000;
  logic [11:0] rm = 12'h000;
  logic ropen = 1'b1;
  logic rshort = 1'b0;
  logic sda_oe, alert_oe, over_oe, scl, h_low, malert, pend;
  wire logic sda;
  wire logic sda_o, alert_o, over_o;
  int n_mismatch = 0;
  int n_tests = 0;
  int lt = 0;
  int rt = 0;
  int lf, rf;
  logic [6:0] mfl = 7'h00;
  logic [7:0] s, d;
  // first six entries double as the limit registers written below
  logic [7:0] radr [11] = '{REG_LOCAL_HIGH, REG_LOCAL_LOW, REG_REMOTE_HIGH,
    REG_REMOTE_LOW, REG_REMOTE_OVER, REG_LOCAL_OVER, REG_RATE, REG_LOCAL_TEMP,
    REG_REMOTE_TEMP, REG_LOCAL_FRAC, REG_REMOTE_FRAC};
  logic [7:0] rval [11] = '{8'h55, 8'h00, 8'h5F, 8'h00, 8'h7D, 8'h55, 8'h07,
    8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] lim [6] = '{8'h40, 8'h14, 8'h60, 8'h10, 8'h70, 8'h50};
  // open-drain data line with pull-up
  assign sda = ~(h_low | sda_oe);
  always #2.5 clk = ~clk;
  // short counts keep the run within a few hundred microseconds
  dts_core #(.SLAVE_ADDR(ADDR), .CONV_CYCLES(2700), .GAP_CYCLES(6000),
    .TIMEOUT_CYCLES(2000)) dut (.CLK(clk), .RESET_N(rst_n), .SCLK_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe), .ALERT_OUT(alert_o),
    .ALERT_OE(alert_oe), .OVERHEAT_SHUTDOWN_OUT(over_o),
    .OVERHEAT_SHUTDOWN_OE(over_oe), .LOCAL_MEAS(lm), .REMOTE_MEAS(rm),
    .REMOTE_OPEN(ropen), .REMOTE_SHORT(rshort));
  dts_smbus_host #(.DEV_ADDR(ADDR)) host (.clk(clk), .scl(scl),
    .sda_low(h_low), .sda(sda));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic int tmain(input logic signed [11:0] x);
    return x < 0 ? 0 : int'(x) / 8;
  endfunction
  function automatic int tfrac(input logic signed [11:0] x);
    return x < 0 ? 0 : int'(x[2:0]) * 32;
  endfunction
  function automatic logic [3:0] cond();
    return {lt >= lim[0], lt < lim[1], rt >= lim[2], rt < lim[3]};
  endfunction
  task automatic model_conv();
    lt = tmain(lm);
    lf = tfrac(lm);
    rt = (ropen | rshort) ? 255 : tmain(rm);
    rf = (ropen | rshort) ? 0 : tfrac(rm);
    mfl = mfl | {cond(), ropen, 2'b00};
    malert = malert | (|cond()) | ropen;
  endtask
  task automatic cmp(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // status read: the model converts once busy is seen low
  task automatic stat();
    host.rd(REG_STATUS, s);
    if (!s[7] && pend) begin
      model_conv();
      pend = 1'b0;
    end
    cmp("status", s & 8'h7F, {1'b0, mfl});
    // read clears flags whose condition, open diode included, is gone
    mfl[6:2] = mfl[6:2] & {cond(), ropen};
    if ({cond(), ropen} == 5'h00) begin
      malert = 1'b0;
    end
  endtask
  task automatic convert();
    host.snd(CMD_ONE_SHOT);
    pend = 1'b1;
    stat();
    cmp("busy", {7'h0, s[7]}, 8'h01);
    for (int i = 0; i < 8 && pend; i++) begin
      stat();
    end
    host.rd(REG_LOCAL_TEMP, d);
    cmp("local", d, 8'(lt));
    host.rd(REG_LOCAL_FRAC, d);
    cmp("local frac", d, 8'(lf));
    host.rd(REG_REMOTE_FRAC, d);
    cmp("remote frac", d, 8'(rf));
    host.rd(REG_REMOTE_TEMP, d);
    cmp("remote", d, 8'(rt));
    host.rcv(ADDR, d);
    cmp("receive", d, 8'(rt));
    cmp("overheat", {7'h0, over_oe},
        {7'h0, lt >= lim[5] || rt >= lim[4]});
    cmp("alert", {7'h0, alert_oe}, {7'h0, malert});
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    malert = 1'b0;
    pend = 1'b0;
    void'($urandom(28584));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    stat();
    host.rd(REG_CONFIG, d);
    cmp("config", d, 8'h00);
    host.wr(REG_CONFIG, 8'h40);
    for (int i = 0; i < 11; i++) begin
      host.rd(radr[i], d);
      cmp("reset value", d, rval[i]);
    end
    for (int i = 0; i < 6; i++) begin
      host.wr(radr[i], lim[i]);
    end
    convert();
    cmp("open flag", {7'h0, s[2]}, 8'h01);
    // alert response names us while alert pends
    host.rcv(ARA_ADDR, d);
    cmp("alert response", d, {ADDR, 1'b0});
    ropen = 1'b0;
    for (int k = 0; k < 4; k++) begin
      lm = 12'(int'($urandom_range(1760)) - 160);
      rm = 12'(int'($urandom_range(1760)) - 160);
      rshort = (k == 1);
      convert();
    end
    lm = 12'(lt * 8 + 40);
    host.wr(REG_CONFIG, 8'h00);
    s = 8'h00;
    for (int i = 0; i < 20 && !s[7]; i++) begin
      stat();
    end
    cmp("run busy", {7'h0, s[7]}, 8'h01);
    host.wr(REG_CONFIG, 8'h40);
    stat();
    cmp("standby idle", {7'h0, s[7]}, 8'h00);
    host.wr(REG_LOCAL_TEMP, 8'hAA);
    host.rd(REG_LOCAL_TEMP, d);
    cmp("kept local", d, 8'(lt));
    host.start();
    host.put_byte({ADDR, 1'b0});
    for (int i = 0; i < 8; i++) begin
      host.put_bit(1'b0);
    end
    repeat (100) @(negedge clk);
    cmp("ack before timeout", {7'h0, sda_oe}, 8'h01);
    repeat (2100) @(negedge clk);
    cmp("timeout release", {7'h0, sda_oe}, 8'h00);
    host.stop();
    host.rcv(7'h33, d);
    cmp("foreign nack", {7'h0, host.acked}, 8'h00);
    cmp("pin levels", {5'h0, sda_o, alert_o, over_o}, 8'h00);
    end_of_test();
  end
  // watchdog: about two fifths above the expected run length
  initial begin
    #450000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
